// ==== rtl/cm_map.svh ====
// Register map, field positions, reset values and limits of the match code comparator
`ifndef CM_MAP_SVH
`define CM_MAP_SVH
// ==========================================
// Register byte offsets
`define CM_OFF_CTRL   8'h00
`define CM_OFF_EVT    8'h04
`define CM_OFF_TYPES  8'h08
`define CM_OFF_HDR1   8'h0c
`define CM_OFF_HDR2   8'h10
`define CM_OFF_ADDR   8'h14
`define CM_OFF_DATA   8'h18
`define CM_OFF_STAT   8'h1c
`define CM_OFF_MASK   8'h20
`define CM_OFF_STATE  8'h24
// ==========================================
// Field positions
`define CM_CTRL_FILT  0
`define CM_CTRL_R1    1
`define CM_CTRL_R2    3
`define CM_CTRL_MODE  5
`define CM_CTRL_CLR   7
`define CM_EVT_OUT1   0
`define CM_EVT_OUT2   2
`define CM_EVT_BEEP   4
`define CM_HDR_LEN    16
`define CM_ADDR_SEL   16
`define CM_ST_RES     0
`define CM_ST_LRN     1
`define CM_ST_FAIL    2
`define CM_ST_REJ     3
`define CM_ST_W       4
`define CM_TYPE_2D    4
// ==========================================
// Reset values
`define CM_CTRL_RST   32'h0000_0000
`define CM_EVT_RST    32'h0000_0019
`define CM_TYPES_RST  32'hffff_7fff
// ==========================================
// Character and length limits
`define CM_CHAR_MIN   8'h20
`define CM_CHAR_MAX   8'h89
`define CM_WILDCARD   8'h23
`define CM_LEN_2D     11'h614
`define CM_LEN_1D     11'h032
`define CM_REF_DEPTH  1556
`define CM_LEN_W      11
`define CM_TYPE_SPEC  5'h0f
`endif

// ==== rtl/cm_pkg.sv ====
// Types shared by the match code comparator
`include "cm_map.svh"
`default_nettype none
package cm_pkg;
   typedef logic [4:0] code_type_t;
   typedef struct packed {
      logic                  valid;
      logic                  last;
      code_type_t            ctype;
      logic [7:0]            data;
   } code_beat_s;
   typedef struct packed {
      code_type_t            ctype;
      logic [`CM_LEN_W-1:0]  len;
   } ref_hdr_s;
   typedef enum logic [2:0] {T_IDLE = 3'b001, T_ARM = 3'b010, T_CAPT = 3'b100} teach_state_e;
   typedef enum logic [1:0] {EV_OFF, EV_MATCH, EV_MISS, EV_GOOD} event_sel_e;
   typedef enum logic [1:0] {REF_FOLLOW, REF_OFF, REF_TEMP, REF_PERM} ref_ctl_e;
endpackage : cm_pkg
`default_nettype wire

// ==== rtl/code_match_top.sv ====
// Match code comparator: reference codes, teach-in, result outputs, output filter
// Functional notes
// - Compare every decoded code against two references
// - Results drive two outputs and beeper
// - Filter off: every code forwarded
// - Filter on: forward only exact reference matches
// - Reference holds type, length, content; hash wildcard
// - Only reference one is learnable by reads
// - Teach trigger learning enables temporary comparison
// - After static teach compare only reference one
// - Temporary lost at power-up; permanent restored
// - Command enable overrides teach trigger enable
// - Characters outside 32..137 rejected
// - Length limit 1556 matrix, 50 bar code
// - Three learning modes: dynamic, static, static variant
// - Static learning may clear daily statistics
// - Learned type, length, content stored nonvolatile; here only nv_store_o pulses, headers reset to zero
// - After learning, unfiltered forwarding keeps all types
`include "cm_map.svh"
`default_nettype none
module code_match_top #(
   parameter int DEPTH = `CM_REF_DEPTH,
   parameter int AW    = `CM_LEN_W
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               pulse_i,
   input  wire cm_pkg::code_beat_s code_i,
   input  wire logic               teach_i,
   input  wire logic [1:0]         nv_flags_i,
   output logic      [1:0]         nv_flags_o,
   output logic                    nv_store_o,
   output logic                    result1_o,
   output logic                    result2_o,
   output logic                    beeper_o,
   output logic                    fwd_valid_o,
   output logic                    fwd_pass_o,
   output logic                    stats_clr_o,
   output logic                    irq_o
);
   // ==========================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      merge = (old & ~m) | (nw & m);
   endfunction : merge
   function automatic logic char_ok(input logic [7:0] c);
      char_ok = (c >= `CM_CHAR_MIN) && (c <= `CM_CHAR_MAX);
   endfunction : char_ok
   function automatic logic len_ok(input logic [AW-1:0] l, input cm_pkg::code_type_t t);
      len_ok = (l != '0) && (l <= (t[`CM_TYPE_2D] ? `CM_LEN_2D : `CM_LEN_1D));
   endfunction : len_ok

   logic [31:0]          ctrl;
   logic [31:0]          evt;
   logic [31:0]          types;
   cm_pkg::ref_hdr_s     hdr [2];
   logic [AW-1:0]        bus_idx;
   logic                 bus_sel;
   logic [`CM_ST_W-1:0]  status;
   logic [`CM_ST_W-1:0]  mask;
   logic [`CM_ST_W-1:0]  next_status;
   logic                 nv_loaded;
   logic [31:0]          rd_mux;
   logic                 req;
   logic                 wr;
   logic                 wr_ctrl;
   logic                 wr_hdr1;
   logic                 wr_hdr2;
   logic                 wr_data;
   logic [31:0]          hdr_new;
   logic                 hdr_bad;
   cm_pkg::teach_state_e tstate;
   logic                 cap_bad;
   logic                 teach_q;
   logic                 teach_tmp;
   logic                 only_ref1;
   logic [AW-1:0]        cidx;
   logic                 in_beat;
   logic                 teach_wr;
   logic                 fin;
   logic                 learn_ok;
   logic                 learn_fail;
   logic [1:0]           mem_we;
   logic [AW-1:0]        mem_wa;
   logic [7:0]           mem_wd;
   logic [7:0]           rbyte [2];
   cm_pkg::code_beat_s   d;
   logic [AW-1:0]        d_idx;
   logic                 d_cap;
   logic [1:0]           mism;
   logic [1:0]           bad_now;
   logic [1:0]           hit;
   logic [1:0]           act;
   logic [1:0]           any_hit;
   logic                 good_rd;
   logic                 p1;
   logic                 p2;
   logic                 matched;
   logic                 eval;
   logic                 bus_rej;

   // ==========================================
   // Wishbone slave: ack one cycle after the request, writes land on the ack edge
   assign req     = wb_cyc_i & wb_stb_i;
   assign wr      = req & wb_we_i & wb_ack_o;
   assign wr_ctrl = wr && (wb_adr_i == `CM_OFF_CTRL);
   assign wr_hdr1 = wr && (wb_adr_i == `CM_OFF_HDR1);
   assign wr_hdr2 = wr && (wb_adr_i == `CM_OFF_HDR2);
   assign wr_data = wr && (wb_adr_i == `CM_OFF_DATA) && wb_sel_i[0];
   assign hdr_new = merge({5'h00, hdr[wr_hdr2].len, 11'h000, hdr[wr_hdr2].ctype},
                          wb_dat_i, wb_sel_i);
   assign hdr_bad = !len_ok(hdr_new[`CM_HDR_LEN +: AW], hdr_new[4:0]);
   assign bus_rej = (wr_data && !char_ok(wb_dat_i[7:0]))
                  || ((wr_hdr1 || wr_hdr2) && hdr_bad);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wb_adr_i == `CM_OFF_CTRL) begin
         rd_mux = ctrl;
      end else if (wb_adr_i == `CM_OFF_EVT) begin
         rd_mux = evt;
      end else if (wb_adr_i == `CM_OFF_TYPES) begin
         rd_mux = types;
      end else if (wb_adr_i == `CM_OFF_HDR1) begin
         rd_mux = {5'h00, hdr[0].len, 11'h000, hdr[0].ctype};
      end else if (wb_adr_i == `CM_OFF_HDR2) begin
         rd_mux = {5'h00, hdr[1].len, 11'h000, hdr[1].ctype};
      end else if (wb_adr_i == `CM_OFF_ADDR) begin
         rd_mux = {15'h0000, bus_sel, 5'h00, bus_idx};
      end else if (wb_adr_i == `CM_OFF_STAT) begin
         rd_mux = {28'h000_0000, status};
      end else if (wb_adr_i == `CM_OFF_MASK) begin
         rd_mux = {28'h000_0000, mask};
      end else if (wb_adr_i == `CM_OFF_STATE) begin
         rd_mux = {20'h0_0000, act, teach_tmp, only_ref1, result1_o, result2_o,
                   beeper_o, 2'b00, tstate};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req && !wb_ack_o) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // ==========================================
   // Configuration; power-up restores permanent enables from the nonvolatile image
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl      <= `CM_CTRL_RST;
         evt       <= `CM_EVT_RST;
         types     <= `CM_TYPES_RST;
         mask      <= '0;
         nv_loaded <= 1'b0;
      end else begin
         if (!nv_loaded) begin
            nv_loaded <= 1'b1;
            ctrl[`CM_CTRL_R1 +: 2] <= nv_flags_i[0] ? cm_pkg::REF_PERM : cm_pkg::REF_FOLLOW;
            ctrl[`CM_CTRL_R2 +: 2] <= nv_flags_i[1] ? cm_pkg::REF_PERM : cm_pkg::REF_OFF;
         end else if (wr_ctrl) begin
            ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
         end
         if (wr && (wb_adr_i == `CM_OFF_EVT)) begin
            evt <= merge(evt, wb_dat_i, wb_sel_i);
         end
         if (wr && (wb_adr_i == `CM_OFF_TYPES)) begin
            types <= merge(types, wb_dat_i, wb_sel_i);
         end
         if (wr && (wb_adr_i == `CM_OFF_MASK)) begin
            mask <= wb_dat_i[`CM_ST_W-1:0];
         end
      end
   end

   // Headers: bus writes for both, learning for reference one only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hdr[0] <= '0;
         hdr[1] <= '0;
      end else begin
         if (learn_ok) begin
            hdr[0] <= '{ctype: code_i.ctype, len: cidx + AW'(1)};
         end else if (wr_hdr1 && !hdr_bad) begin
            hdr[0] <= '{ctype: hdr_new[4:0], len: hdr_new[`CM_HDR_LEN +: AW]};
         end
         if (wr_hdr2 && !hdr_bad) begin
            hdr[1] <= '{ctype: hdr_new[4:0], len: hdr_new[`CM_HDR_LEN +: AW]};
         end
      end
   end

   // Content pointer auto-increments on each data write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_idx <= '0;
         bus_sel <= 1'b0;
      end else if (wr && (wb_adr_i == `CM_OFF_ADDR)) begin
         bus_idx <= wb_dat_i[AW-1:0];
         bus_sel <= wb_dat_i[`CM_ADDR_SEL];
      end else if (wr_data) begin
         bus_idx <= bus_idx + AW'(1);
      end
   end

   // ==========================================
   // Teach-in via the trigger input
   assign in_beat  = code_i.valid & pulse_i;
   assign fin      = (tstate != cm_pkg::T_IDLE) && in_beat && code_i.last;
   // Dynamic and plain static need the type enabled; the variant also takes the special type
   assign learn_ok = fin && !(cap_bad && tstate == cm_pkg::T_CAPT)
                   && char_ok(code_i.data)
                   && (types[code_i.ctype] && (code_i.ctype != `CM_TYPE_SPEC)
                       || (ctrl[`CM_CTRL_MODE +: 2] == 2'd2
                           && code_i.ctype == `CM_TYPE_SPEC))
                   && len_ok(cidx + AW'(1), code_i.ctype);
   assign learn_fail = fin && !learn_ok;
   assign teach_wr   = (tstate != cm_pkg::T_IDLE) && in_beat && char_ok(code_i.data);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tstate  <= cm_pkg::T_IDLE;
         cap_bad <= 1'b0;
         teach_q <= 1'b0;
      end else begin
         teach_q <= teach_i;
         case (tstate)
            cm_pkg::T_IDLE: begin
               if (teach_i && !teach_q) begin
                  tstate <= cm_pkg::T_ARM;
               end
            end
            cm_pkg::T_ARM: begin
               if (in_beat) begin
                  cap_bad <= !char_ok(code_i.data);
                  tstate  <= code_i.last ? cm_pkg::T_IDLE : cm_pkg::T_CAPT;
               end
            end
            cm_pkg::T_CAPT: begin
               if (in_beat) begin
                  cap_bad <= cap_bad | !char_ok(code_i.data);
                  if (code_i.last) begin
                     tstate <= cm_pkg::T_IDLE;
                  end
               end
            end
            default: tstate <= cm_pkg::T_IDLE;
         endcase
      end
   end

   // Temporary enable lives only until power-off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         teach_tmp   <= 1'b0;
         only_ref1   <= 1'b0;
         stats_clr_o <= 1'b0;
         nv_store_o  <= 1'b0;
         nv_flags_o  <= 2'b00;
      end else begin
         if (learn_ok) begin
            teach_tmp <= 1'b1;
         end
         if (learn_ok && ctrl[`CM_CTRL_MODE +: 2] != 2'd0) begin
            only_ref1 <= 1'b1;
         end else if (wr_ctrl) begin
            only_ref1 <= 1'b0;
         end
         stats_clr_o <= learn_ok && ctrl[`CM_CTRL_MODE +: 2] != 2'd0 && ctrl[`CM_CTRL_CLR];
         nv_store_o  <= learn_ok || wr_ctrl;
         nv_flags_o  <= {ctrl[`CM_CTRL_R2 +: 2] == cm_pkg::REF_PERM,
                         ctrl[`CM_CTRL_R1 +: 2] == cm_pkg::REF_PERM};
      end
   end

   // Reference one: command setting wins, only follow lets the trigger decide; reference two: temp or perm unless static learning masks it
   assign act[0] = (ctrl[`CM_CTRL_R1 +: 2] == cm_pkg::REF_FOLLOW) ? teach_tmp
                 : ctrl[`CM_CTRL_R1 + 1];
   assign act[1] = ctrl[`CM_CTRL_R2 + 1] && !only_ref1;

   // ==========================================
   // Reference stores; a learning read writes only reference one
   always_comb begin
      mem_we = 2'b00;
      mem_wa = bus_idx;
      mem_wd = wb_dat_i[7:0];
      if (teach_wr) begin
         mem_we[0] = 1'b1;
         mem_wa    = cidx;
         mem_wd    = code_i.data;
      end else if (wr_data && char_ok(wb_dat_i[7:0])) begin
         mem_we[bus_sel] = 1'b1;
      end
   end

   // Beat index of the incoming code, doubles as read address
   always_ff @(posedge clk_i) begin
      if (rst_i || (pulse_i && !p1)) begin
         cidx <= '0;
      end else if (in_beat) begin
         cidx <= code_i.last ? '0 : ((&cidx) ? cidx : cidx + AW'(1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         d     <= '0;
         d_idx <= '0;
         d_cap <= 1'b0;
      end else begin
         d       <= code_i;
         d.valid <= in_beat;
         d_idx   <= cidx;
         d_cap   <= (tstate != cm_pkg::T_IDLE) && in_beat;
      end
   end

   // Comparison runs one cycle behind the input, aligned with the registered read
   for (genvar r = 0; r < 2; r++) begin : g_ref
      ref_code_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
         .clk_i   (clk_i),
         .we_i    (mem_we[r]),
         .waddr_i (mem_wa),
         .wdata_i (mem_wd),
         .raddr_i (cidx),
         .rdata_o (rbyte[r])
      );
      assign bad_now[r] = !(rbyte[r] == d.data || rbyte[r] == `CM_WILDCARD)
                        || (d_idx >= hdr[r].len);
      // A code being learned is not judged against its own half-written reference
      assign hit[r] = d.valid && d.last && !mism[r] && !bad_now[r] && !(d_cap && r == 0)
                    && d.ctype == hdr[r].ctype && (d_idx + AW'(1)) == hdr[r].len;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mism[r] <= 1'b0;
         end else if (d.valid) begin
            mism[r] <= d.last ? 1'b0 : (mism[r] | bad_now[r]);
         end
      end
   end

   // Without filter every code passes, learning does not narrow it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_valid_o <= 1'b0;
         fwd_pass_o  <= 1'b0;
      end else begin
         fwd_valid_o <= d.valid && d.last;
         fwd_pass_o  <= !ctrl[`CM_CTRL_FILT] || |(hit & act);
      end
   end

   // ==========================================
   // Per-pulse result, evaluated one cycle after the pulse falls
   assign eval    = p2 && !p1;
   assign matched = (|act) && (&(any_hit | ~act));

   function automatic logic ev(input logic [1:0] s, input logic m, input logic a,
                               input logic g);
      case (cm_pkg::event_sel_e'(s))
         cm_pkg::EV_MATCH: ev = m;
         cm_pkg::EV_MISS:  ev = a && !m;
         cm_pkg::EV_GOOD:  ev = g;
         default:          ev = 1'b0;
      endcase
   endfunction : ev

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p1        <= 1'b0;
         p2        <= 1'b0;
         any_hit   <= 2'b00;
         good_rd   <= 1'b0;
         result1_o <= 1'b0;
         result2_o <= 1'b0;
         beeper_o  <= 1'b0;
      end else begin
         p1 <= pulse_i;
         p2 <= p1;
         if (pulse_i && !p1) begin
            any_hit <= 2'b00;
            good_rd <= 1'b0;
         end else begin
            any_hit <= any_hit | hit;
            good_rd <= good_rd | (d.valid && d.last);
         end
         if (eval) begin
            result1_o <= ev(evt[`CM_EVT_OUT1 +: 2], matched, |act, good_rd);
            result2_o <= ev(evt[`CM_EVT_OUT2 +: 2], matched, |act, good_rd);
            beeper_o  <= ev(evt[`CM_EVT_BEEP +: 2], matched, |act, good_rd);
         end
      end
   end

   // ==========================================
   // Sticky status, write one to clear, set wins over clear
   always_comb begin
      next_status = status;
      if (wr && (wb_adr_i == `CM_OFF_STAT)) begin
         next_status = status & ~wb_dat_i[`CM_ST_W-1:0];
      end
      next_status = next_status | {bus_rej, learn_fail, learn_ok, eval};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
         irq_o  <= 1'b0;
      end else begin
         status <= next_status;
         irq_o  <= |(next_status & mask);
      end
   end

   // ==========================================
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_filter_off_pass: assert property (
      (d.valid && d.last && !ctrl[`CM_CTRL_FILT]) |=> (fwd_valid_o && fwd_pass_o))
      else $error("code dropped with filter off");
   a_filter_on_drop: assert property (
      (d.valid && d.last && ctrl[`CM_CTRL_FILT] && !(|(hit & act))) |=> !fwd_pass_o)
      else $error("unmatched code forwarded with filter on");
   a_result_held: assert property (!eval |=> $stable({result1_o, result2_o, beeper_o}))
      else $error("result changed outside evaluation");
   a_teach_enables: assert property (learn_ok |=> teach_tmp && nv_store_o)
      else $error("learning did not enable comparison and store");
   a_static_only_ref1: assert property (
      (learn_ok && ctrl[`CM_CTRL_MODE +: 2] != 2'd0) |=> !act[1])
      else $error("reference two active after static learning");
   a_cmd_precedence: assert property (
      (ctrl[`CM_CTRL_R1 +: 2] == cm_pkg::REF_OFF) |-> !act[0])
      else $error("trigger overrode command setting");
   a_char_reject: assert property (
      (wr_data && !char_ok(wb_dat_i[7:0])) |-> (mem_we == 2'b00 ##1 status[`CM_ST_REJ]))
      else $error("illegal character accepted");
   a_ref2_not_learned: assert property (teach_wr |-> !mem_we[1])
      else $error("learning wrote reference two");
   a_stats_clear: assert property (
      (learn_ok && ctrl[`CM_CTRL_CLR] && ctrl[`CM_CTRL_MODE +: 2] != 2'd0) |=> stats_clr_o)
      else $error("statistics not cleared on static learning");
   a_irq_level: assert property ($rose(irq_o) |-> $past(|(next_status & mask)))
      else $error("interrupt without unmasked status");
endmodule : code_match_top
`default_nettype wire

// ==== rtl/ref_code_mem.sv ====
// Content store of one reference code, registered read
`include "cm_map.svh"
`default_nettype none
module ref_code_mem #(
   parameter int DEPTH = `CM_REF_DEPTH,
   parameter int AW    = `CM_LEN_W
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [7:0]    wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [7:0]    rdata_o
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_i) begin
      if (we_i && (int'(waddr_i) < DEPTH)) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   // Out-of-range reads return zero, which never equals a legal character
   always_ff @(posedge clk_i) begin
      rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : 8'h00;
   end
endmodule : ref_code_mem
`default_nettype wire

// ==== test/code_match_top_test.sv ====
// Self-checking bench of the match code comparator
`include "cm_map.svh"
`default_nettype none
module code_match_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [1:0]  nvf, nvfo;
   logic [3:0]  sel, lanes;
   logic        teach, pulse, ack, r1, r2, bp, fv, fp, nvs, sc, irq, pq;
   cm_pkg::code_beat_s beat;
   int          fail_count = 0, checked = 0, ticks = 0, st_n = 0, clr_n = 0;
   always #5 clk_i = ~clk_i;
   code_match_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pulse_i(pulse), .code_i(beat), .teach_i(teach),
      .nv_flags_i(nvf), .nv_flags_o(nvfo), .nv_store_o(nvs), .result1_o(r1),
      .result2_o(r2), .beeper_o(bp), .fwd_valid_o(fv), .fwd_pass_o(fp),
      .stats_clr_o(sc), .irq_o(irq));
   code_src_model src_u (.clk_i(clk_i), .pulse_o(pulse), .teach_o(teach), .code_o(beat));
   // ======================================
   // One-cycle pulses are counted at every edge, so none is missed
   always @(posedge clk_i) begin
      ticks++;
      st_n += int'(nvs === 1'b1);
      clr_n += int'(sc === 1'b1);
      if (fv === 1'b1)
         pq = fp;
      if (ticks == 20000) begin
         fail_count++;
         test_done();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, lanes};
      @(posedge clk_i iff ack === 1'b1);
      q = rdat;
      {cyc, stb} <= 2'h0;
   endtask : wb
   task code(input logic [4:0] t, input logic [15:0] d, input logic exp);
      pq = 1'bx;
      src_u.code2(t, d);
      chk(pq, exp, "forward verdict");
   endtask : code
   task test_done();
      $display("fail_count=%0d checked=%0d", fail_count, checked);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // ======================================
   // Scenarios
   task t_regs();
      wb(1'b0, `CM_OFF_EVT, '0);
      chk(q, `CM_EVT_RST, "event reset");
      lanes = 4'h1;
      wb(1'b1, `CM_OFF_EVT, 32'h0000_ff3f);
      lanes = 4'hf;
      wb(1'b0, `CM_OFF_EVT, '0);
      chk(q, 32'h0000_003f, "byte lane");
      wb(1'b1, `CM_OFF_EVT, `CM_EVT_RST);
      wb(1'b0, `CM_OFF_TYPES, '0);
      chk(q, `CM_TYPES_RST, "types reset");
      wb(1'b0, 8'h40, '0);
      chk(q, 32'h0000_0000, "unmapped");
   endtask : t_regs
   task t_ref2();
      wb(1'b1, `CM_OFF_HDR2, 32'h0002_0001);
      wb(1'b1, `CM_OFF_ADDR, 32'h0001_0000);
      wb(1'b1, `CM_OFF_DATA, 32'h0000_0041);
      wb(1'b1, `CM_OFF_DATA, 32'h0000_0023);
      wb(1'b1, `CM_OFF_CTRL, 32'h0000_0011);
      src_u.pulse(1'b1);
      code(5'h01, 16'h4142, 1'b1);
      code(5'h02, 16'h4142, 1'b0);
      code(5'h01, 16'h4241, 1'b0);
      src_u.pulse(1'b0);
      chk({r1, r2, bp}, 3'h5, "match result");
      wb(1'b1, `CM_OFF_CTRL, 32'h0000_0010);
      src_u.pulse(1'b1);
      code(5'h02, 16'h4142, 1'b1);
      src_u.pulse(1'b0);
      chk({r1, r2, bp}, 3'h2, "miss result");
   endtask : t_ref2
   task t_reject();
      logic [31:0] v [5];
      v = '{32'h0000_001f, 32'h0000_008a, 32'h0033_0001, 32'h0000_0020, 32'h0000_0089};
      wb(1'b1, `CM_OFF_MASK, 32'h0000_0008);
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, `CM_OFF_STAT, 32'h0000_000f);
         wb(1'b1, i == 2 ? `CM_OFF_HDR2 : `CM_OFF_DATA, v[i]);
         wb(1'b0, `CM_OFF_STAT, '0);
         chk({q[3], irq}, {2{i < 3}}, "reject flag");
      end
   endtask : t_reject
   task t_teach();
      int s0;
      wb(1'b1, `CM_OFF_CTRL, 32'h0000_00b0);
      src_u.teach();
      s0 = st_n;
      src_u.pulse(1'b1);
      code(5'h03, 16'h3132, 1'b1);
      src_u.pulse(1'b0);
      chk(st_n - s0, 1, "store pulse");
      chk(clr_n, 1, "stats clear");
      wb(1'b0, `CM_OFF_STATE, '0);
      chk(q[10:8], 3'h7, "teach state");
      wb(1'b0, `CM_OFF_HDR1, '0);
      chk(q, 32'h0002_0003, "learned header");
      wb(1'b0, `CM_OFF_HDR2, '0);
      chk(q, 32'h0002_0001, "second untouched");
      src_u.pulse(1'b1);
      code(5'h01, 16'h4444, 1'b1);
      code(5'h03, 16'h3132, 1'b1);
      src_u.pulse(1'b0);
      chk({r1, r2, bp}, 3'h5, "first only");
      wb(1'b1, `CM_OFF_CTRL, 32'h0000_00b2);
      wb(1'b0, `CM_OFF_STATE, '0);
      chk(q[10], 1'b0, "command wins");
   endtask : t_teach
   task t_power();
      {rst_i, nvf} <= 3'h5;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `CM_OFF_STATE, '0);
      chk(q[9], 1'b0, "temp lost");
      wb(1'b0, `CM_OFF_CTRL, '0);
      chk(q[2:1], 2'h3, "perm restored");
      chk(nvfo, 2'h1, "perm flags");
   endtask : t_power
   initial begin
      {cyc, stb, we, adr, wdat, nvf, sel} <= '0;
      lanes = 4'hf;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_regs();
      t_ref2();
      t_reject();
      t_teach();
      t_power();
      test_done();
   end
endmodule : code_match_top_test
`default_nettype wire

// ==== test/code_src_model.sv ====
// Decoder side model: reading pulse, code beats, teach trigger
`default_nettype none
module code_src_model (
   input  wire logic          clk_i,
   output logic               pulse_o,
   output logic               teach_o,
   output cm_pkg::code_beat_s code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {pulse_o, teach_o, code_o} = '0;
   // ======================================
   // Sequencing; a code always ends before the pulse falls
   task pulse(input logic on);
      @(posedge clk_i);
      pulse_o <= on;
      repeat (4) @(posedge clk_i);
   endtask : pulse
   // Idle byte is the inverse of the last one, never a stale copy
   task code2(input logic [4:0] t, input logic [15:0] d);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         code_o <= {1'b1, i == 1, t, d[15-8*i -: 8]};
      end
      @(posedge clk_i);
      code_o <= {2'h0, t, ~d[7:0]};
      repeat (4) @(posedge clk_i);
   endtask : code2
   task teach();
      @(posedge clk_i);
      teach_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      teach_o <= 1'b0;
   endtask : teach
endmodule : code_src_model
`default_nettype wire
